// ===== lkd_core.sv
// lkd_core.sv: lock-detect window, lock flag, pump controls, AXI4-Lite registers
// assumes: pd_ref_in and pd_vco_in arrive from outside the mclk domain;
// the analog pump consumes the control outputs.
`timescale 1ns/1ns
`include "lkd_defs.svh"
module lkd_core (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // phase detector inputs
  input  wire logic        pd_ref_in,
  input  wire logic        pd_vco_in,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // charge pump controls
  output logic             pump_up,
  output logic             pump_dn,
  output logic             pump_tristate,
  output logic             pd_invert,
  output logic             csp_boost,
  output logic [6:0]       gain_up,
  output logic [6:0]       gain_dn,
  output logic [6:0]       offset_mag,
  output logic             offset_up_en,
  output logic             offset_dn_en,
  // lock and interrupt
  output logic             lock_flag,
  output logic             irq
);
  import lkd_pkg::*;

  // all state in one struct, registered in one place
  lkd_top_t    q;
  lkd_top_t    d;
  logic        ref_rise;
  logic        vco_rise;
  logic        win_hit;
  logic        win_miss;
  logic        win_pend;
  logic        win_ref_first;
  logic        win_csp;
  logic [9:0]  win_len;
  logic [9:0]  csp_len;
  logic [9:0]  tmr_per;
  logic [13:0] target;
  logic        lkd_en;
  logic        hit;
  logic        miss;
  logic [2:0]  ev;
  logic [2:0]  clr;
  logic        up_raw;
  logic        dn_raw;

  // byte-lane merge of a write into a 24-bit register
  function automatic logic [23:0] merge(input logic [23:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [23:0] r;
    r = old;
    for (int i = 0; i < 3; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = data[i*8 +: 8];
    end
    return r;
  endfunction

  // word index of a byte address
  function automatic logic [5:0] word_idx(input logic [7:0] addr);
    return addr[7:2];
  endfunction

  // window cycles: half a period for divider 0, never shorter than one cycle
  function automatic logic [9:0] timer_window(input logic [9:0] per,
                                              input logic [2:0] div);
    logic [9:0] w;
    w = (per << div) >> 1;
    if (w == 10'h000)
      w = 10'h001;
    return w;
  endfunction

  // slip threshold in cycles; a three-bit sum so code 3 does not wrap to zero
  function automatic logic [9:0] slip_len(input logic [1:0] code);
    logic [2:0] sh;
    sh = 3'(code) + 3'(`LKD_CSP_SHIFT);
    return 10'h001 << sh;
  endfunction

  // hit run target; a four-bit sum so the longer codes do not wrap
  function automatic logic [13:0] run_target(input logic [2:0] code);
    logic [3:0] sh;
    sh = 4'(code) + 4'(`LKD_LOCK_SHIFT);
    return 14'h0001 << sh;
  endfunction

  // pins come from another clock, so each passes the three-stage filter
  lkd_sync u_sync_ref (
    .mclk (mclk),
    .rst  (rst),
    .din  (pd_ref_in),
    .rise (ref_rise)
  );

  lkd_sync u_sync_vco (
    .mclk (mclk),
    .rst  (rst),
    .din  (pd_vco_in),
    .rise (vco_rise)
  );

  // timer period from speed, scaled by the divider
  always_comb
  begin
    case (q.lock_cfg[`LKD_F_SPEED_HI:`LKD_F_SPEED_LO])
      2'h0:    tmr_per = `LKD_TMR_P0;
      2'h1:    tmr_per = `LKD_TMR_P1;
      2'h2:    tmr_per = `LKD_TMR_P2;
      default: tmr_per = `LKD_TMR_P3;
    endcase
  end

  // fixed window when the timer window is not selected
  always_comb
  begin
    win_len = timer_window(tmr_per, q.lock_cfg[`LKD_F_DIV_HI:`LKD_F_DIV_LO]);
    if (!q.lock_cfg[`LKD_F_WIN_SEL])
      win_len = 10'(`LKD_FIXED_WIN_CYC);
  end

  assign csp_len = slip_len(q.pd_ctrl[`LKD_F_CSP_HI:`LKD_F_CSP_LO]);
  assign target  = run_target(q.lock_cfg[`LKD_F_COUNT_HI:`LKD_F_COUNT_LO]);

  // both arrivals pass equal filters, so their spacing is kept
  lkd_window u_window (
    .mclk      (mclk),
    .rst       (rst),
    .ref_rise  (ref_rise),
    .vco_rise  (vco_rise),
    .win_len   (win_len),
    .csp_len   (csp_len),
    .hit       (win_hit),
    .miss      (win_miss),
    .pending   (win_pend),
    .ref_first (win_ref_first),
    .cycle_slip_guard       (win_csp)
  );

  // detection off: the window still runs, only its verdicts are dropped
  assign lkd_en = q.lock_cfg[`LKD_F_ENABLE];
  assign hit    = lkd_en & win_hit;
  assign miss   = lkd_en & win_miss;

  always_comb
  begin
    d   = q;
    clr = 3'h0;

    // lock run counter and flag
    if (!lkd_en)
    begin
      d.hits = 14'h0000;
      d.lock = 1'b0;
    end
    else if (miss)
    begin
      d.hits = 14'h0000;
      d.lock = 1'b0;
    end
    else if (hit)
    begin
      // saturate so a long run keeps the flag without wrapping
      if (q.hits < target)
        d.hits = q.hits + 14'h0001;
      if (q.hits + 14'h0001 >= target)
        d.lock = 1'b1;
    end

    // one write at a time; a second waits for the response handshake
    // write channel: address and data taken in either order
    if (s_axi_awvalid && q.awready)
    begin
      d.aw_full = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready)
    begin
      d.w_full = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    if (q.aw_full && q.w_full && !q.bvalid)
    begin
      d.aw_full = 1'b0;
      d.w_full  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = 2'h0;
      case (word_idx(q.aw_addr))
        `LKD_IDX_LOCK_CFG: d.lock_cfg = merge(q.lock_cfg, q.w_data, q.w_strb);
        `LKD_IDX_PUMP_CFG: d.pump_cfg = merge(q.pump_cfg, q.w_data, q.w_strb);
        `LKD_IDX_PD_CTRL:  d.pd_ctrl  = merge(q.pd_ctrl, q.w_data, q.w_strb);
        `LKD_IDX_INT_EN:
        begin
          if (q.w_strb[0])
            d.int_en = q.w_data[2:0];
        end
        `LKD_IDX_INT_CLR:
        begin
          if (q.w_strb[0])
            clr = q.w_data[2:0];
        end
        `LKD_IDX_STATUS, `LKD_IDX_INT_STS:
          d.bresp = 2'h0;
        default:
          d.bresp = 2'h2;
      endcase
    end
    // no new beat is taken until the response has gone
    d.awready = !d.aw_full && !d.bvalid;
    d.wready  = !d.w_full && !d.bvalid;

    // read channel
    // reads answer one edge after the address is taken
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (s_axi_arvalid && q.arready)
    begin
      d.rvalid = 1'b1;
      d.rresp  = 2'h0;
      d.rdata  = 32'h00000000;
      case (word_idx(s_axi_araddr))
        `LKD_IDX_LOCK_CFG: d.rdata[23:0] = q.lock_cfg;
        `LKD_IDX_PUMP_CFG: d.rdata[23:0] = q.pump_cfg;
        `LKD_IDX_PD_CTRL:  d.rdata[23:0] = q.pd_ctrl;
        `LKD_IDX_STATUS:
        begin
          d.rdata[`LKD_F_STS_LOCK] = q.lock;
          // a window waiting for its second arrival
          d.rdata[`LKD_F_STS_OPEN] = win_pend;
        end
        `LKD_IDX_INT_STS:  d.rdata[2:0] = q.int_sts;
        `LKD_IDX_INT_EN:   d.rdata[2:0] = q.int_en;
        `LKD_IDX_INT_CLR:  d.rdata = 32'h00000000;
        default:           d.rresp = 2'h2;
      endcase
    end
    d.arready = !d.rvalid;

    // sticky events, a set in the clear cycle survives
    ev[`LKD_INT_GAINED] = d.lock & ~q.lock;
    ev[`LKD_INT_LOST]   = q.lock & ~d.lock;
    ev[`LKD_INT_MISS]   = miss;
    d.int_sts = (q.int_sts & ~clr) | ev;
    d.irq     = |(d.int_sts & d.int_en);

    // pump direction: reference leading means the vco lags, pump up
    up_raw = win_pend & win_ref_first;
    dn_raw = win_pend & ~win_ref_first;
    if (q.pd_ctrl[`LKD_F_POL])
    begin
      up_raw = win_pend & ~win_ref_first;
      dn_raw = win_pend & win_ref_first;
    end
    d.pump_up   = up_raw & d.pd_ctrl[`LKD_F_UP_EN];
    d.pump_dn   = dn_raw & d.pd_ctrl[`LKD_F_DN_EN];
    d.tristate  = !d.pd_ctrl[`LKD_F_UP_EN] && !d.pd_ctrl[`LKD_F_DN_EN];
    d.csp_boost = win_csp & !d.tristate;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q          <= '0;
      q.lock_cfg <= `LKD_RST_LOCK_CFG;
      q.pump_cfg <= `LKD_RST_PUMP_CFG;
      // both pump enables on out of reset, so the loop starts closed
      q.pd_ctrl  <= `LKD_RST_PD_CTRL;
      q.tristate <= 1'b0;
    end
    else
      q <= d;
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign pump_up       = q.pump_up;
  assign pump_dn       = q.pump_dn;
  assign pump_tristate = q.tristate;
  assign pd_invert     = q.pd_ctrl[`LKD_F_POL];
  assign csp_boost     = q.csp_boost;
  assign gain_up       = q.pump_cfg[`LKD_F_GAIN_UP_HI:`LKD_F_GAIN_UP_LO];
  assign gain_dn       = q.pump_cfg[`LKD_F_GAIN_DN_HI:`LKD_F_GAIN_DN_LO];
  assign offset_mag    = q.pump_cfg[`LKD_F_OFS_HI:`LKD_F_OFS_LO];
  assign offset_up_en  = q.pump_cfg[`LKD_F_OFS_UP_EN];
  assign offset_dn_en  = q.pump_cfg[`LKD_F_OFS_DN_EN];
  assign lock_flag     = q.lock;
  assign irq           = q.irq;
endmodule

// ===== lkd_defs.svh
// lkd_defs.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the core, sync, window and test files
`ifndef LKD_DEFS_SVH
`define LKD_DEFS_SVH

// register indices, byte address is four times the index
`define LKD_IDX_LOCK_CFG   6'h07
`define LKD_IDX_PUMP_CFG   6'h09
`define LKD_IDX_PD_CTRL    6'h0b
`define LKD_IDX_STATUS     6'h12
`define LKD_IDX_INT_STS    6'h13
`define LKD_IDX_INT_EN     6'h14
`define LKD_IDX_INT_CLR    6'h15

// lock_detect_config fields
`define LKD_F_COUNT_LO     0
`define LKD_F_COUNT_HI     2
`define LKD_F_ENABLE       3
`define LKD_F_WIN_SEL      6
`define LKD_F_DIV_LO       7
`define LKD_F_DIV_HI       9
`define LKD_F_SPEED_LO     10
`define LKD_F_SPEED_HI     11

// pump_current_config fields
`define LKD_F_GAIN_UP_LO   0
`define LKD_F_GAIN_UP_HI   6
`define LKD_F_GAIN_DN_LO   7
`define LKD_F_GAIN_DN_HI   13
`define LKD_F_OFS_LO       14
`define LKD_F_OFS_HI       20
`define LKD_F_OFS_UP_EN    21
`define LKD_F_OFS_DN_EN    22

// phase_detector_control fields
`define LKD_F_POL          4
`define LKD_F_UP_EN        5
`define LKD_F_DN_EN        6
`define LKD_F_CSP_LO       7
`define LKD_F_CSP_HI       8

// status and interrupt bits
`define LKD_F_STS_OPEN     0
`define LKD_F_STS_LOCK     1
`define LKD_INT_GAINED     0
`define LKD_INT_LOST       1
`define LKD_INT_MISS       2

// reset values
`define LKD_RST_LOCK_CFG   24'h000000
`define LKD_RST_PUMP_CFG   24'h000000
`define LKD_RST_PD_CTRL    24'h000060

// timing: clock rate and fixed window
`define LKD_CLK_MHZ        100
`define LKD_FIXED_WIN_NS   10
`define LKD_FIXED_WIN_CYC  ((`LKD_FIXED_WIN_NS * `LKD_CLK_MHZ) / 1000)

// timer periods in clock cycles, speed code 0 fastest
`define LKD_TMR_P0         10'h001
`define LKD_TMR_P1         10'h002
`define LKD_TMR_P2         10'h003
`define LKD_TMR_P3         10'h004

// consecutive hit target is 1 << (code + base)
`define LKD_LOCK_SHIFT     6
// phase error threshold in cycles is 1 << (code + base)
`define LKD_CSP_SHIFT      1

`endif

// ===== lkd_pkg.sv
// lkd_pkg.sv: state types of the lock-window and pump control block
// assumes: lkd_defs.svh holds every number
package lkd_pkg;

  typedef enum logic [1:0] {WIN_IDLE, WIN_OPEN, WIN_LATE} lkd_win_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic rise;
  } lkd_sync_t;

  typedef struct packed {
    lkd_win_state_t st;
    logic           ref_first;
    logic [9:0]     cnt;
    logic           hit;
    logic           miss;
    logic           cycle_slip_guard;
  } lkd_win_t;

  typedef struct packed {
    logic [23:0] lock_cfg;
    logic [23:0] pump_cfg;
    logic [23:0] pd_ctrl;
    logic [2:0]  int_sts;
    logic [2:0]  int_en;
    logic        irq;
    logic [13:0] hits;
    logic        lock;
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        pump_up;
    logic        pump_dn;
    logic        tristate;
    logic        csp_boost;
  } lkd_top_t;

endpackage

// ===== lkd_sync.sv
// lkd_sync.sv: three-stage synchroniser with agreement filter and rise pulse
// assumes: din is asynchronous to mclk
`timescale 1ns/1ns
`include "lkd_defs.svh"
module lkd_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // pin side
  input  wire logic din,
  // core side
  output logic      rise
);
  import lkd_pkg::*;

  lkd_sync_t q;
  lkd_sync_t d;

  always_comb
  begin
    d      = q;
    d.s1   = din;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.rise = 1'b0;
    // a level counts only once stages two and three agree
    if (q.s2 == q.s3 && q.s2 != q.lvl)
    begin
      d.lvl  = q.s2;
      d.rise = q.s2;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign rise = q.rise;
endmodule

// ===== lkd_window.sv
// lkd_window.sv: lock window opened by whichever phase-detector input leads
// assumes: ref_rise and vco_rise are single-cycle pulses on mclk
`timescale 1ns/1ns
`include "lkd_defs.svh"
module lkd_window (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // arrivals
  input  wire logic       ref_rise,
  input  wire logic       vco_rise,
  // window length and slip threshold, in cycles
  input  wire logic [9:0] win_len,
  input  wire logic [9:0] csp_len,
  // results
  output logic            hit,
  output logic            miss,
  output logic            pending,
  output logic            ref_first,
  output logic            cycle_slip_guard
);
  import lkd_pkg::*;

  lkd_win_t q;
  lkd_win_t d;
  logic     other;

  always_comb
  begin
    d      = q;
    d.hit  = 1'b0;
    d.miss = 1'b0;
    other  = q.ref_first ? vco_rise : ref_rise;
    case (q.st)
      WIN_IDLE:
      begin
        d.cnt = 10'h000;
        d.cycle_slip_guard = 1'b0;
        if (ref_rise && vco_rise)
          d.hit = 1'b1;
        else if (ref_rise || vco_rise)
        begin
          d.st        = WIN_OPEN;
          d.ref_first = ref_rise;
          d.cnt       = 10'h001;
        end
      end
      WIN_OPEN, WIN_LATE:
      begin
        d.cnt = (q.cnt == 10'h3ff) ? q.cnt : q.cnt + 10'h001;
        if (q.cnt >= csp_len)
          d.cycle_slip_guard = 1'b1;
        if (q.st == WIN_OPEN && q.cnt >= win_len)
          d.st = WIN_LATE;
        if (other)
        begin
          d.hit  = (q.st == WIN_OPEN) && (q.cnt < win_len);
          d.miss = !d.hit;
          d.st   = WIN_IDLE;
          d.cycle_slip_guard  = 1'b0;
        end
      end
      default:
        d.st = WIN_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

  assign hit       = q.hit;
  assign miss      = q.miss;
  assign pending   = (q.st != WIN_IDLE);
  assign ref_first = q.ref_first;
  assign cycle_slip_guard       = q.cycle_slip_guard;
endmodule

// ===== lkd_core_assertions.sv
// lkd_core_assertions.sv: port-level checks of the lock-window block
// assumes: bound to lkd_core, sees its ports only
`timescale 1ns/1ns
module lkd_core_assertions (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  // pump controls
  input wire logic        pump_up,
  input wire logic        pump_dn,
  input wire logic        pump_tristate,
  input wire logic        pd_invert,
  input wire logic        csp_boost,
  input wire logic [6:0]  gain_up,
  input wire logic [6:0]  gain_dn,
  input wire logic [6:0]  offset_mag,
  input wire logic        offset_up_en,
  input wire logic        offset_dn_en,
  // lock and interrupt
  input wire logic        lock_flag,
  input wire logic        irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_tri_quiet;
    pump_tristate |-> !pump_up && !pump_dn;
  endproperty
  a_tri_quiet: assert property (p_tri_quiet)
    else $error("pump drives while tri-stated");

  property p_csp_gate;
    pump_tristate |-> !csp_boost;
  endproperty
  a_csp_gate: assert property (p_csp_gate)
    else $error("gain boost while tri-stated");

  // pump settings move only with a completed write
  property p_cfg_write;
    $changed({gain_up, gain_dn, offset_mag, offset_up_en, offset_dn_en, pd_invert})
      |-> $rose(s_axi_bvalid);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("pump setting changed without a write");

  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");

  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp});
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped early");

  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse)
    else $error("read address taken while data pending");

  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");

  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_b_answer;
    s_both_taken |=> ##1 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer)
    else $error("write answer late");

  property p_bresp_code;
    s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2;
  endproperty
  a_bresp_code: assert property (p_bresp_code)
    else $error("bad write response code");

  c_lock: cover property ($rose(lock_flag));
  c_irq: cover property ($rose(irq));
  c_csp: cover property ($rose(csp_boost));
  c_slverr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
endmodule

bind lkd_core lkd_core_assertions u_lkd_core_assertions (.*);

// ===== lkd_core_test.sv
// lkd_core_test.sv: self-checking bench for the lock-window block
// assumes: design and checker compiled first; bench drives all ports
`timescale 1ns/1ns
`include "lkd_defs.svh"
module lkd_core_test;
  import lkd_pkg::*;
  logic        mclk = '0, rst = '1, pd_ref_in = '0, pd_vco_in = '0;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        pump_up, pump_dn, pump_tristate, pd_invert, csp_boost;
  logic [6:0]  gain_up, gain_dn, offset_mag;
  logic        offset_up_en, offset_dn_en, lock_flag, irq, s_up, s_dn, s_csp;
  int          mismatches = 0, comparisons = 0, cyc = 0;

  lkd_core u_lkd_core (.*);

  always #5 mclk = ~mclk;

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // window cycles for speed and divider codes: period is speed plus one
  function automatic int exp_win(input int spd, input int dv);
    int w;
    w = ((spd + 1) << dv) / 2;
    return (w == 0) ? 1 : w;
  endfunction

  // slip threshold cycles for a code
  function automatic int exp_slip(input int code);
    return 2 << code;
  endfunction

  // bready raised late so a standing response is seen
  task automatic wr(input logic [5:0] i, input logic [31:0] d, input logic [1:0] er);
    bit a, w;
    a = 0;
    w = 0;
    @(posedge mclk);
    s_axi_awvalid <= '1;
    s_axi_wvalid  <= '1;
    s_axi_awaddr  <= {i, 2'h0};
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    while (!(a && w))
    begin
      @(posedge mclk);
      a = a | (s_axi_awready === 1'h1);
      w = w | (s_axi_wready === 1'h1);
      s_axi_awvalid <= !a;
      s_axi_wvalid  <= !w;
    end
    repeat (2) @(posedge mclk);
    s_axi_bready <= '1;
    do @(posedge mclk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= '0;
    chk("bresp", s_axi_bresp, er);
  endtask

  task automatic rc(input logic [5:0] i, input logic [31:0] e, input logic [1:0] er);
    @(posedge mclk);
    s_axi_arvalid <= '1;
    s_axi_araddr  <= {i, 2'h0};
    do @(posedge mclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= '0;
    @(posedge mclk);
    s_axi_rready <= '1;
    do @(posedge mclk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= '0;
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    chk("rdata", rv, e);
    chk("rresp", rr, er);
  endtask

  task automatic tick();
    @(posedge mclk);
    s_up  = s_up | pump_up;
    s_dn  = s_dn | pump_dn;
    s_csp = s_csp | csp_boost;
  endtask

  // one arrival pair: leader first, the other d cycles later
  task automatic arr(input logic rl, input int d);
    s_up  = 0;
    s_dn  = 0;
    s_csp = 0;
    @(posedge mclk);
    pd_ref_in <= rl | (d == 0);
    pd_vco_in <= !rl | (d == 0);
    repeat (d) tick();
    if (d > 0)
    begin
      pd_ref_in <= '1;
      pd_vco_in <= '1;
    end
    repeat (8) tick();
    pd_ref_in <= '0;
    pd_vco_in <= '0;
    repeat (8) tick();
  endtask

  initial
  begin
    int wl, d, th, c;
    logic rl, pol;
    logic [31:0] x;
    void'($urandom(32'h4ad07f39));
    repeat (6) @(posedge mclk);
    rst <= '0;
    repeat (2) @(posedge mclk);
    rc(`LKD_IDX_LOCK_CFG, `LKD_RST_LOCK_CFG, 2'h0);
    rc(`LKD_IDX_PUMP_CFG, `LKD_RST_PUMP_CFG, 2'h0);
    rc(`LKD_IDX_PD_CTRL, `LKD_RST_PD_CTRL, 2'h0);
    rc(`LKD_IDX_STATUS, 32'h0, 2'h0);
    rc(`LKD_IDX_INT_EN, 32'h0, 2'h0);
    rc(`LKD_IDX_INT_CLR, 32'h0, 2'h0);
    rc(6'h3f, 32'h0, 2'h2);
    wr(6'h3f, 32'hffffffff, 2'h2);
    wr(`LKD_IDX_STATUS, 32'hffffffff, 2'h0);
    rc(`LKD_IDX_STATUS, 32'h0, 2'h0);
    chk("tri", pump_tristate, 32'h0);
    $display("test reset done");
    for (c = 0; c < 4; c++)
    begin
      x = (c == 0) ? 32'hff3fffff : $urandom;
      x[22] = !x[21];
      wr(`LKD_IDX_PUMP_CFG, x, 2'h0);
      chk("gup", gain_up, x[6:0]);
      chk("gdn", gain_dn, x[13:7]);
      chk("ofs", {offset_dn_en, offset_up_en, offset_mag}, x[22:14]);
      rc(`LKD_IDX_PUMP_CFG, x[23:0], 2'h0);
    end
    for (c = 0; c < 4; c++)
    begin
      pol = $urandom;
      wr(`LKD_IDX_PD_CTRL, c * 32 + pol * 16, 2'h0);
      repeat (2) @(posedge mclk);
      chk("tri", pump_tristate, c == 0);
      chk("inv", pd_invert, pol);
    end
    wr(`LKD_IDX_PD_CTRL, 32'h60, 2'h0);
    $display("test pump done");
    wr(`LKD_IDX_INT_EN, 32'h7, 2'h0);
    repeat (64) arr(1'h1, 0);
    arr(1'h1, 6);
    chk("lkoff", lock_flag, 32'h0);
    rc(`LKD_IDX_INT_STS, 32'h0, 2'h0);
    wr(`LKD_IDX_LOCK_CFG, 32'h8, 2'h0);
    for (c = 0; c < 2; c++)
    begin
      repeat (63) arr(1'h1, 0);
      chk("lk63", lock_flag, 32'h0);
      arr(1'h0, 0);
      chk("lk64", lock_flag, 32'h1);
      rc(`LKD_IDX_STATUS, 32'h2, 2'h0);
      rc(`LKD_IDX_INT_STS, 32'h1, 2'h0);
      chk("irq", irq, 32'h1);
      wr(`LKD_IDX_INT_CLR, 32'h7, 2'h0);
      @(posedge mclk);
      chk("irq", irq, 32'h0);
      repeat (5) arr(1'h1, 0);
      chk("lkhold", lock_flag, 32'h1);
      arr(c[0], 6);
      chk("lkmiss", lock_flag, 32'h0);
      rc(`LKD_IDX_INT_STS, 32'h6, 2'h0);
      chk("irq", irq, 32'h1);
      wr(`LKD_IDX_INT_EN, 32'h0, 2'h0);
      @(posedge mclk);
      chk("irq", irq, 32'h0);
      rc(`LKD_IDX_INT_STS, 32'h6, 2'h0);
      wr(`LKD_IDX_INT_CLR, 32'h7, 2'h0);
      wr(`LKD_IDX_INT_EN, 32'h7, 2'h0);
    end
    $display("test lock done");
    // every divider code once, every speed and slip code twice
    for (c = 0; c < 8; c++)
    begin
      wl = exp_win((c * 3) % 4, c);
      th = exp_slip(c % 4);
      pol = $urandom;
      rl = $urandom;
      wr(`LKD_IDX_LOCK_CFG, 32'h48 | (c << 7) | (((c * 3) % 4) << 10), 2'h0);
      wr(`LKD_IDX_PD_CTRL, 32'h60 | (pol << 4) | ((c % 4) << 7), 2'h0);
      wr(`LKD_IDX_INT_CLR, 32'h7, 2'h0);
      d = wl / 2;
      arr(rl, d);
      rc(`LKD_IDX_INT_STS, 32'h0, 2'h0);
      if (d > th + 2)
        chk("csp", s_csp, 32'h1);
      if (d + 2 < th)
        chk("csp", s_csp, 32'h0);
      if (d > 3)
        chk("up", s_up, rl ^ pol);
      if (d > 3)
        chk("dn", s_dn, !(rl ^ pol));
      arr(!rl, wl + 4);
      rc(`LKD_IDX_INT_STS, 32'h4, 2'h0);
    end
    $display("test window done");
    results();
  end
endmodule
